// File: core/fep_ctrl.sv
// top: flash erase and access-protection controller
// Notes on behaviour
// - 256 KB array in 1 KB blocks; each block erases alone.
// - a finished erase leaves every bit of the block at one.
// - protection is held per 2 KB pair of erase blocks.
// - each unit may be read-only or execute-only; unmarked units are open.
// - erase and program to a read-only unit are refused.
// - erase and program to an execute-only unit are refused.
// - execute-only units answer instruction fetches only; data and debug reads denied.
`timescale 1ns/100ps
`default_nettype none
module fep_ctrl #(
  parameter int unsigned UNITS = fep_pkg::NUM_UNITS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // request port
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire fep_pkg::fep_op_t req_op_i,
  input wire fep_pkg::fep_src_t req_src_i,
  input wire logic [fep_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [fep_pkg::WORD_W-1:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic rsp_denied_o,
  output logic [fep_pkg::WORD_W-1:0] rsp_rdata_o,
  // protection setting
  input wire logic prot_we_i,
  input wire logic [$clog2(UNITS)-1:0] prot_unit_i,
  input wire logic prot_ro_i,
  input wire logic prot_xo_i,
  output logic [UNITS-1:0] prot_ro_o,
  output logic [UNITS-1:0] prot_xo_o,
  // sticky violation flag
  input wire logic viol_clr_i,
  output logic viol_o
);
  localparam int unsigned WAW = fep_pkg::ADDR_W - fep_pkg::WORD_LSB;
  localparam int unsigned BWW = fep_pkg::BLOCK_LSB - fep_pkg::WORD_LSB;
  localparam int unsigned UW = $clog2(UNITS);

  typedef enum logic [1:0] {
    FEP_IDLE,
    FEP_READ,
    FEP_ERASE,
    FEP_DONE
  } fep_state_t;

  // array words are not reset: a block reads unknown until its first erase
  fep_mem_if #(.AW(WAW), .DW(fep_pkg::WORD_W)) mem_bus ();

  fep_mem #(.AW(WAW), .DW(fep_pkg::WORD_W)) u_mem (
    .clk_i(clk_i),
    .mp(mem_bus.mem)
  );

  // protection unit index: the address bits above the 2 KB boundary
  function automatic logic [UW-1:0] unit_of(input logic [fep_pkg::ADDR_W-1:0] a);
    unit_of = a[fep_pkg::UNIT_LSB +: UW];
  endfunction

  fep_state_t state_q, state_d;
  logic [UNITS-1:0] ro_q, ro_d, xo_q, xo_d;
  logic viol_q, viol_d;
  logic [WAW-1:0] waddr_q, waddr_d;
  logic [BWW-1:0] ecnt_q, ecnt_d;
  logic rsp_valid_q, rsp_valid_d;
  logic denied_q, denied_d;
  logic [fep_pkg::WORD_W-1:0] rdata_q, rdata_d;
  logic [fep_pkg::WORD_W-1:0] wdata_q, wdata_d;
  logic take, deny, u_ro, u_xo, refuse;
  logic [UW-1:0] u;

  // ready comes straight from the state so a new request may follow a response at once
  assign req_ready_o = (state_q == FEP_IDLE);
  assign take = req_valid_i && req_ready_o;
  assign u = unit_of(req_addr_i);
  assign u_ro = ro_q[u];
  assign u_xo = xo_q[u];

  // a unit marked both ways behaves as execute-only and still refuses writes
  always_comb begin
    deny = 1'b0;
    if (req_op_i == fep_pkg::FEP_OP_READ) begin
      deny = u_xo && (req_src_i != fep_pkg::FEP_SRC_IFETCH);
    end else begin
      deny = u_ro || u_xo;
    end
  end
  assign refuse = take && deny;

  // protection maps: a write lands at the edge, so a request in the same cycle is judged by the old setting
  always_comb begin
    ro_d = ro_q;
    xo_d = xo_q;
    if (prot_we_i) begin
      ro_d[prot_unit_i] = prot_ro_i;
      xo_d[prot_unit_i] = prot_xo_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ro_q <= '0;
      xo_q <= '0;
    end else begin
      ro_q <= ro_d;
      xo_q <= xo_d;
    end
  end

  // a refusal in the clearing cycle wins, so no violation is ever lost
  always_comb begin
    viol_d = viol_q;
    if (viol_clr_i) begin
      viol_d = 1'b0;
    end
    if (refuse) begin
      viol_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      viol_q <= 1'b0;
    end else begin
      viol_q <= viol_d;
    end
  end

  // transfer engine: one request at a time, answer registered
  always_comb begin
    state_d = state_q;
    waddr_d = waddr_q;
    ecnt_d = ecnt_q;
    rsp_valid_d = 1'b0;
    denied_d = denied_q;
    rdata_d = rdata_q;
    wdata_d = wdata_q;
    mem_bus.we = 1'b0;
    mem_bus.addr = waddr_q;
    mem_bus.wdata = fep_pkg::ERASED_WORD;
    case (state_q)
      FEP_IDLE: begin
        if (take) begin
          waddr_d = req_addr_i[fep_pkg::ADDR_W-1:fep_pkg::WORD_LSB];
          mem_bus.addr = waddr_d;
          denied_d = deny;
          rdata_d = '0;
          wdata_d = req_wdata_i;
          if (deny) begin
            rsp_valid_d = 1'b1;
          end else if (req_op_i == fep_pkg::FEP_OP_READ) begin
            state_d = FEP_READ;
          end else if (req_op_i == fep_pkg::FEP_OP_PROG) begin
            // flash programming can only clear bits
            mem_bus.we = 1'b0;
            state_d = FEP_DONE;
          end else begin
            waddr_d[BWW-1:0] = '0;
            ecnt_d = '0;
            state_d = FEP_ERASE;
          end
        end
      end
      FEP_READ: begin
        // the array register holds the word addressed at the take edge
        rdata_d = mem_bus.rdata;
        rsp_valid_d = 1'b1;
        state_d = FEP_IDLE;
      end
      FEP_ERASE: begin
        // one word per cycle: a 1 KB block costs 256 cycles, no long count needed
        mem_bus.we = 1'b1;
        mem_bus.wdata = fep_pkg::ERASED_WORD;
        waddr_d = waddr_q + WAW'(1);
        ecnt_d = ecnt_q + BWW'(1);
        if (ecnt_q == {BWW{1'b1}}) begin
          rsp_valid_d = 1'b1;
          state_d = FEP_IDLE;
        end
      end
      FEP_DONE: begin
        // old word was read at the take edge; the AND keeps bits that are already zero
        mem_bus.we = 1'b1;
        mem_bus.wdata = mem_bus.rdata & wdata_q;
        rsp_valid_d = 1'b1;
        state_d = FEP_IDLE;
      end
      default: state_d = FEP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= FEP_IDLE;
      waddr_q <= '0;
      ecnt_q <= '0;
      rsp_valid_q <= 1'b0;
      denied_q <= 1'b0;
      rdata_q <= '0;
      wdata_q <= '0;
    end else begin
      state_q <= state_d;
      waddr_q <= waddr_d;
      ecnt_q <= ecnt_d;
      rsp_valid_q <= rsp_valid_d;
      denied_q <= denied_d;
      rdata_q <= rdata_d;
      wdata_q <= wdata_d;
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_denied_o = denied_q;
  assign rsp_rdata_o = rdata_q;
  assign prot_ro_o = ro_q;
  assign prot_xo_o = xo_q;
  assign viol_o = viol_q;
endmodule
`default_nettype wire

// File: core/fep_pkg.sv
// package: constants and types for the flash erase/protect controller
package fep_pkg;
  localparam int unsigned ARRAY_BYTES = 262144;
  localparam int unsigned BLOCK_BYTES = 1024;
  localparam int unsigned UNIT_BYTES = 2048;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
  localparam int unsigned NUM_WORDS = ARRAY_BYTES / WORD_BYTES;
  localparam int unsigned NUM_UNITS = ARRAY_BYTES / UNIT_BYTES;
  localparam int unsigned BLOCK_LSB = 10;
  localparam int unsigned UNIT_LSB = 11;
  localparam int unsigned WORD_LSB = 2;
  localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
  typedef enum logic [1:0] {
    FEP_OP_READ,
    FEP_OP_PROG,
    FEP_OP_ERASE
  } fep_op_t;
  typedef enum logic [1:0] {
    FEP_SRC_IFETCH,
    FEP_SRC_DATA,
    FEP_SRC_DEBUG
  } fep_src_t;
endpackage

// File: core/fep_mem_if.sv
// interface: word port between the controller and its flash array model
`timescale 1ns/100ps
`default_nettype none
interface fep_mem_if #(
  parameter int unsigned AW = 16,
  parameter int unsigned DW = 32
);
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: core/fep_mem.sv
// memory: flash array word storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module fep_mem #(
  parameter int unsigned AW = 16,
  parameter int unsigned DW = 32
) (
  input wire logic clk_i,
  fep_mem_if.mem mp
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  // no reset on the array: flash contents survive a system reset
  always_ff @(posedge clk_i) begin
    if (mp.we) begin
      store[mp.addr] <= mp.wdata;
    end
    rdata_q <= store[mp.addr];
  end

  assign mp.rdata = rdata_q;
endmodule
`default_nettype wire

// File: tb/fep_req_model.sv
// requester model: fetch, data and debugger side of the controller
`timescale 1ns/100ps
`default_nettype none
module fep_req_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic rsp_i,
  output logic valid_o = 1'h0,
  output fep_pkg::fep_op_t op_o = fep_pkg::FEP_OP_READ,
  output fep_pkg::fep_src_t src_o = fep_pkg::FEP_SRC_DATA,
  output logic [17:0] addr_o = 18'h00000,
  output logic [31:0] wdata_o = 32'h0000_0000
);
  task access(input fep_pkg::fep_op_t o, input fep_pkg::fep_src_t s, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk_i);
    valid_o <= 1'h1;
    op_o <= o;
    src_o <= s;
    addr_o <= a;
    wdata_o <= d;
    @(negedge clk_i);
    for (int n = 0; n < 9 && !ready_i; n++) @(negedge clk_i);
    @(posedge clk_i);
    valid_o <= 1'h0;
    // released address and write data carry junk so a late sample cannot pass
    addr_o <= ~a;
    wdata_o <= ~d;
    for (int n = 0; n < 300 && rsp_i !== 1'h1; n++) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: tb/fep_ctrl_assertions.sv
// checker: port assertions of the flash protect controller
`timescale 1ns/100ps
`default_nettype none
module fep_ctrl_assertions #(
  parameter int unsigned UNITS = 128
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire fep_pkg::fep_op_t req_op_i,
  input wire fep_pkg::fep_src_t req_src_i,
  input wire logic [17:0] req_addr_i,
  input wire logic rsp_valid_o,
  input wire logic rsp_denied_o,
  input wire logic [UNITS-1:0] prot_ro_o,
  input wire logic [UNITS-1:0] prot_xo_o,
  input wire logic viol_clr_i,
  input wire logic viol_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tk, wr, ro, xo, bad;
  assign tk = req_valid_i && req_ready_o;
  assign wr = req_op_i != fep_pkg::FEP_OP_READ;
  assign ro = prot_ro_o[req_addr_i[17:11]];
  assign xo = prot_xo_o[req_addr_i[17:11]];
  assign bad = wr && (ro || xo) || !wr && xo && req_src_i != fep_pkg::FEP_SRC_IFETCH;
  chk_ro_refused: assert property (tk && wr && ro |=> rsp_valid_o && rsp_denied_o) else $error("ro write");
  chk_xo_refused: assert property (tk && wr && xo |=> rsp_valid_o && rsp_denied_o) else $error("xo write");
  chk_xo_read: assert property (tk && !wr && xo && req_src_i != fep_pkg::FEP_SRC_IFETCH |=> rsp_denied_o)
    else $error("xo read");
  chk_viol_set: assert property (tk && bad |=> viol_o) else $error("no viol");
  chk_viol_hold: assert property (viol_o && !viol_clr_i |=> viol_o) else $error("viol lost");
  chk_erase_time: assert property (tk && req_op_i == fep_pkg::FEP_OP_ERASE && !bad |-> ##257 rsp_valid_o)
    else $error("erase time");
  chk_read_open: assert property (tk && !wr && !bad |-> ##2 rsp_valid_o && !rsp_denied_o)
    else $error("read");
  chk_busy_one: assert property (tk && !bad |=> !req_ready_o) else $error("ready");
  cover property (tk && bad);
  cover property (tk && req_op_i == fep_pkg::FEP_OP_ERASE);
  cover property (viol_o && viol_clr_i);
endmodule
bind fep_ctrl fep_ctrl_assertions #(.UNITS(UNITS)) i_chk (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .req_op_i(req_op_i), .req_src_i(req_src_i), .req_addr_i(req_addr_i),
  .rsp_valid_o(rsp_valid_o), .rsp_denied_o(rsp_denied_o), .prot_ro_o(prot_ro_o), .prot_xo_o(prot_xo_o),
  .viol_clr_i(viol_clr_i), .viol_o(viol_o));
`default_nettype wire

// File: tb/fep_ctrl_bench.sv
// bench: directed tests of the flash protect controller
`timescale 1ns/100ps
`default_nettype none
module fep_ctrl_bench;
  localparam fep_pkg::fep_op_t RD = fep_pkg::FEP_OP_READ;
  localparam fep_pkg::fep_op_t PG = fep_pkg::FEP_OP_PROG;
  localparam fep_pkg::fep_op_t ER = fep_pkg::FEP_OP_ERASE;
  localparam fep_pkg::fep_src_t IF = fep_pkg::FEP_SRC_IFETCH;
  localparam fep_pkg::fep_src_t DT = fep_pkg::FEP_SRC_DATA;
  localparam fep_pkg::fep_src_t DB = fep_pkg::FEP_SRC_DEBUG;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic pwe = 1'h0, pro = 1'h0, pxo = 1'h0, vclr = 1'h0;
  logic [6:0] pu = 7'h00;
  logic valid, ready, rsp, den, viol;
  fep_pkg::fep_op_t op;
  fep_pkg::fep_src_t src;
  logic [17:0] addr;
  logic [31:0] wd, rd;
  logic [127:0] rom, xom;
  int err_count = 0;
  int checks_done = 0;
  always #25 clk_i = ~clk_i;
  fep_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(valid), .req_ready_o(ready), .req_op_i(op),
    .req_src_i(src), .req_addr_i(addr), .req_wdata_i(wd), .rsp_valid_o(rsp), .rsp_denied_o(den), .rsp_rdata_o(rd),
    .prot_we_i(pwe), .prot_unit_i(pu), .prot_ro_i(pro), .prot_xo_i(pxo), .prot_ro_o(rom), .prot_xo_o(xom),
    .viol_clr_i(vclr), .viol_o(viol));
  fep_req_model i_req (.clk_i(clk_i), .ready_i(ready), .rsp_i(rsp), .valid_o(valid), .op_o(op), .src_o(src),
    .addr_o(addr), .wdata_o(wd));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // refused or write answers carry zero read data
  task acc(input fep_pkg::fep_op_t o, input fep_pkg::fep_src_t s, input logic [17:0] a, input logic [31:0] d,
           input logic e, input logic [31:0] r);
    i_req.access(o, s, a, d);
    check({31'h0, rsp}, 32'h1);
    check({31'h0, den}, {31'h0, e});
    check(rd, r);
  endtask
  task prot(input logic [6:0] u, input logic r, input logic x);
    @(posedge clk_i);
    pwe <= 1'h1;
    pu <= u;
    pro <= r;
    pxo <= x;
    @(posedge clk_i);
    pwe <= 1'h0;
    @(negedge clk_i);
    check({30'h0, rom[u], xom[u]}, {30'h0, r, x});
  endtask
  task t_erase;
    acc(ER, DT, 18'h00000, 32'h0, 1'h0, 32'h0);
    acc(ER, DT, 18'h00400, 32'h0, 1'h0, 32'h0);
    acc(PG, DT, 18'h00000, 32'h1234_5678, 1'h0, 32'h0);
    acc(PG, DT, 18'h00000, 32'hFFFF_00FF, 1'h0, 32'h0);
    acc(ER, DT, 18'h007FC, 32'h0, 1'h0, 32'h0);
    acc(RD, DT, 18'h007FC, 32'h0, 1'h0, 32'hFFFF_FFFF);
    acc(RD, DT, 18'h00000, 32'h0, 1'h0, 32'h1234_0078);
    $display("t_erase done");
  endtask
  task t_ro;
    prot(7'h00, 1'h1, 1'h0);
    acc(PG, DT, 18'h00000, 32'h0, 1'h1, 32'h0);
    acc(ER, DT, 18'h00400, 32'h0, 1'h1, 32'h0);
    check({31'h0, viol}, 32'h1);
    acc(RD, DB, 18'h00000, 32'h0, 1'h0, 32'h1234_0078);
    $display("t_ro done");
  endtask
  task t_xo;
    prot(7'h00, 1'h0, 1'h1);
    acc(ER, DT, 18'h00000, 32'h0, 1'h1, 32'h0);
    acc(PG, IF, 18'h00004, 32'h0, 1'h1, 32'h0);
    acc(RD, DT, 18'h00000, 32'h0, 1'h1, 32'h0);
    acc(RD, DB, 18'h007FC, 32'h0, 1'h1, 32'h0);
    acc(RD, IF, 18'h00000, 32'h0, 1'h0, 32'h1234_0078);
    $display("t_xo done");
  endtask
  task t_clr;
    @(posedge clk_i);
    vclr <= 1'h1;
    @(posedge clk_i);
    vclr <= 1'h0;
    acc(ER, DT, 18'h00800, 32'h0, 1'h0, 32'h0);
    check({31'h0, viol}, 32'h0);
    $display("t_clr done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    t_erase;
    t_ro;
    t_xo;
    t_clr;
    test_done;
  end
  initial begin
    #300000;
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire
